// >>> inc/ctp_pkg.sv
package ctp_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NCH   = 8;
	localparam int NMSG  = 2;
	localparam int NSLOT = 4;

	// ****************************************
	// Register byte addresses, message word stride and word offsets
	// ****************************************
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_DECIM  = 8'h04;
	localparam logic [7:0] A_ZID    = 8'h08;
	localparam logic [7:0] A_SID    = 8'h0C;
	localparam logic [7:0] A_BITPOS = 8'h10;
	localparam logic [7:0] A_AZEN   = 8'h14;
	localparam logic [7:0] A_STAT   = 8'h18;
	localparam logic [7:0] A_MASK   = 8'h1C;
	localparam logic [7:0] A_STATE  = 8'h20;
	localparam logic [7:0] A_MSG0   = 8'h40;
	localparam int         MSG_STRIDE = 8;
	localparam logic [2:0] MO_ID    = 3'h0;
	localparam logic [2:0] MO_LEN   = 3'h1;
	localparam logic [2:0] MO_SLOT  = 3'h2;
	localparam logic [2:0] MO_WORDS = 3'h6;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int C_EXT    = 0;
	localparam int C_IGNACK = 1;
	localparam int C_MEAS   = 2;
	localparam int C_STDERR = 3;
	localparam int C_ZACT   = 4;
	localparam int C_SACT   = 5;
	localparam int BP_Z     = 0;
	localparam int BP_S     = 8;
	localparam int SL_CH    = 0;
	localparam int SL_USE   = 3;
	localparam int SL_OFS   = 4;
	localparam int SL_SGN   = 10;
	localparam int SL_BIG   = 11;
	localparam int ID_ACT   = 31;
	localparam int ST_SENT  = 0;
	localparam int ST_ACK   = 1;
	localparam int ST_ZERO  = 2;
	localparam int ST_SHUNT = 3;
	localparam int ST_SERR  = 4;
	localparam int ST_W     = 5;

	// ****************************************
	// Values
	// ****************************************
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [15:0] NEG_FS     = 16'h8000;
	localparam logic [28:0] STD_IDMASK = 29'h0000_07FF;
	localparam logic [3:0]  MAX_LEN    = 4'h8;
	localparam logic [1:0]  RESP_OK    = 2'h0;
	localparam logic [1:0]  RESP_ERR   = 2'h2;

	typedef enum logic [1:0] {S_IDLE, S_BUILD, S_SEND, S_WAIT} ctp_tx_e;

endpackage : ctp_pkg

// >>> hw/ctp_slot_fmt.sv
`timescale 1ns/100ps
module ctp_slot_fmt import ctp_pkg::*;
(
	// Channel value and slot layout
	input  wire logic [15:0] value,
	input  wire logic [5:0]  bit_ofs,
	input  wire logic        use_slot,
	input  wire logic        is_signed,
	input  wire logic        big_end,
	// Payload contribution
	output logic      [63:0] field
);
	logic [15:0] enc;
	logic [15:0] ord;

	assign enc   = is_signed ? value : {~value[15], value[14:0]}; // see [RULE7]
	assign ord   = big_end ? {enc[7:0], enc[15:8]} : enc; // see [RULE8]
	// Bits pushed past bit 63 are lost; software must keep slots inside the frame.
	assign field = use_slot ? ({48'h0, ord} << bit_ofs) : 64'h0; // see [RULE6]

endmodule : ctp_slot_fmt

// >>> hw/ctp_rc_rx.sv
`timescale 1ns/100ps
module ctp_rc_rx import ctp_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Received frames
	input  wire logic        rx_valid,
	input  wire logic [28:0] rx_id,
	input  wire logic        rx_ext,
	input  wire logic [63:0] rx_data,
	// Configuration
	input  wire logic        cfg_ext,
	input  wire logic [28:0] zero_id,
	input  wire logic [28:0] shunt_id,
	input  wire logic        zero_act,
	input  wire logic        shunt_act,
	input  wire logic [5:0]  zero_pos,
	input  wire logic [5:0]  shunt_pos,
	// Results
	output logic             zero_pulse_q,
	output logic             shunt_chg_q,
	output logic             shunt_q
);
	logic [28:0] idm;
	logic        hit_z;
	logic        hit_s;
	logic        bit_z;
	logic        bit_s;
	logic        zlast_q;

	assign idm   = cfg_ext ? 29'h1FFF_FFFF : STD_IDMASK; // see [RULE1]
	assign hit_z = rx_valid && zero_act && rx_ext == cfg_ext && (rx_id & idm) == (zero_id & idm); // see [RULE10]
	assign hit_s = rx_valid && shunt_act && rx_ext == cfg_ext && (rx_id & idm) == (shunt_id & idm); // see [RULE10]
	assign bit_z = rx_data[zero_pos]; // see [RULE11]
	assign bit_s = rx_data[shunt_pos]; // see [RULE11]

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			zlast_q      <= 1'b0;
			zero_pulse_q <= 1'b0;
		end
		else
		begin
			zero_pulse_q <= hit_z && bit_z && !zlast_q; // see [RULE13]
			if (hit_z)
				zlast_q <= bit_z; // see [RULE18]
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			shunt_q     <= 1'b0;
			shunt_chg_q <= 1'b0;
		end
		else
		begin
			shunt_chg_q <= hit_s && bit_s != shunt_q;
			if (hit_s)
				shunt_q <= bit_s; // see [RULE12] [RULE18]
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_zero_once: assert property (hit_z && bit_z && zlast_q |=> !zero_pulse_q) // see [RULE13]
		else $error("Zero adjust retriggered without the bit returning to 0.");
	a_shunt_level: assert property (hit_s |=> shunt_q == $past(bit_s)) // see [RULE12]
		else $error("Shunt state does not follow the received bit.");

endmodule : ctp_rc_rx

// >>> hw/ctp_packer.sv
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Identifiers are 29 bits with the extended option, else 11 bits.
// [RULE2] With ignore-acknowledge set, unacknowledged frames do not stop transmission.
// [RULE3] Only one of every N samples is put into frames.
// [RULE4] Only messages whose active flag is set produce frames.
// [RULE5] Each message has a payload length of at most eight bytes.
// [RULE6] Each mapped channel's 16-bit value starts at its configured bit offset.
// [RULE7] Sign flag clear gives offset binary, set gives two's complement.
// [RULE8] Byte-order flag clear gives little-endian, set gives big-endian.
// [RULE9] Several messages with own identifiers, at most four channels each.
// [RULE10] Remote-control frames are accepted only while their active flag is set.
// [RULE11] Each remote function is one bit at a configured payload position.
// [RULE12] Shunt bit rising switches the test resistor on, falling switches it off.
// [RULE13] Zero adjust starts only on a rising bit; it must return to 0 first.
// [RULE14] Zero adjust zeroes only channels with zero adjustment enabled.
// [RULE15] Measurement frames are sent only in measuring mode.
// [RULE16] Transmission error gives negative full scale, or last value with standard handling.
// [RULE17] Automatic measure option enters measuring mode right after reset.
// [RULE18] Last remote bits are kept from zero after reset for edge detection.
// [RULE19] Payload bits not used by any channel are sent as zero.
module ctp_packer import ctp_pkg::*;
(
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            reset,
	// AXI4-Lite register port
	input  wire logic [7:0]      s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	output logic      [1:0]      s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	input  wire logic [7:0]      s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	output logic      [31:0]     s_axi_rdata,
	output logic      [1:0]      s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	// Interrupt and strap
	output logic                 irq,
	input  wire logic            auto_measure,
	// Channel samples
	input  wire logic            smp_valid,
	input  wire logic [NCH*16-1:0] smp_data,
	input  wire logic [NCH-1:0]  smp_err,
	// Frames to the CAN controller
	output logic                 tx_valid,
	input  wire logic            tx_ready,
	output logic      [28:0]     tx_id,
	output logic                 tx_ext,
	output logic      [3:0]      tx_dlc,
	output logic      [63:0]     tx_data,
	input  wire logic            tx_done,
	input  wire logic            tx_ack_err,
	// Frames from the CAN controller
	input  wire logic            rx_valid,
	input  wire logic [28:0]     rx_id,
	input  wire logic            rx_ext,
	input  wire logic [63:0]     rx_data,
	// Test resistor and mode
	output logic                 test_resistor_on,
	output logic                 test_resistor_off,
	output logic                 measuring
);
	logic [31:0]      reg_q [32];
	logic [ST_W-1:0]  stat_q;
	logic [ST_W-1:0]  stat_ev;
	logic [7:0]       awa_q;
	logic [31:0]      wd_q;
	logic [3:0]       ws_q;
	logic             awh_q;
	logic             wh_q;
	logic             bvalid_q;
	logic [1:0]       bresp_q;
	logic             rvalid_q;
	logic [31:0]      rdata_q;
	logic [1:0]       rresp_q;
	logic             wr_go;
	logic             rd_go;
	logic             boot_q;
	logic             irq_q;
	logic [31:0]      ctrl;
	logic             meas;
	logic [15:0]      n_eff;
	logic [15:0]      dec_q;
	logic             fire;
	logic [15:0]      raw_q [NCH];
	logic [15:0]      zofs_q [NCH];
	logic [15:0]      val_q [NCH];
	logic             zero_pulse;
	logic             shunt_chg;
	logic             shunt_on;
	ctp_tx_e          st_q;
	logic [NMSG-1:0]  pend_q;
	logic [NMSG-1:0]  act;
	logic             halt_q;
	logic [0:0]       cur_q;
	logic [0:0]       sel;
	logic [3:0]       len_eff;
	logic [63:0]      len_mask;
	logic [63:0]      fld [NSLOT];
	logic [63:0]      payload;
	logic [28:0]      tx_id_q;
	logic             tx_ext_q;
	logic [3:0]       tx_dlc_q;
	logic [63:0]      tx_data_q;

	function automatic logic mapped(input logic [7:0] a);
		mapped = !a[7] && (a <= A_STATE || (a >= A_MSG0 && a[4:2] < MO_WORDS));
	endfunction : mapped

	function automatic logic [4:0] msg_ix(input logic [0:0] m, input logic [2:0] w);
		msg_ix = 5'(int'(A_MSG0[6:2]) + int'(m) * MSG_STRIDE + int'(w));
	endfunction : msg_ix

	// ****************************************
	// Register port
	// ****************************************
	assign s_axi_awready = !awh_q && !bvalid_q;
	assign s_axi_wready  = !wh_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign wr_go         = awh_q && wh_q && !bvalid_q;
	assign rd_go         = s_axi_arvalid && !rvalid_q;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			awh_q    <= 1'b0;
			wh_q     <= 1'b0;
			awa_q    <= 8'h00;
			wd_q     <= 32'h0000_0000;
			ws_q     <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OK;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awh_q <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wh_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				awh_q    <= 1'b0;
				wh_q     <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= mapped(awa_q) ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OK;
		end
		else if (rd_go)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
			if (!mapped(s_axi_araddr))
				rdata_q <= 32'h0000_0000;
			else if (s_axi_araddr == A_STAT)
				rdata_q <= 32'(stat_q);
			else if (s_axi_araddr == A_STATE)
				rdata_q <= {28'h0, halt_q, st_q != S_IDLE, shunt_on, meas};
			else
				rdata_q <= reg_q[s_axi_araddr[6:2]];
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// The strap is sampled by a clocked process after reset release, never by the reset itself.
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			boot_q <= 1'b1;
			for (int i = 0; i < 32; i++)
				reg_q[i] <= RST_WORD;
		end
		else
		begin
			boot_q <= 1'b0;
			if (wr_go && mapped(awa_q) && awa_q != A_STAT && awa_q != A_STATE)
				for (int b = 0; b < 4; b++)
					if (ws_q[b])
						reg_q[awa_q[6:2]][b*8 +: 8] <= wd_q[b*8 +: 8];
			if (boot_q && auto_measure)
				reg_q[A_CTRL[6:2]][C_MEAS] <= 1'b1; // see [RULE17]
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	assign stat_ev[ST_SENT]  = st_q == S_WAIT && tx_done;
	assign stat_ev[ST_ACK]   = st_q == S_WAIT && tx_ack_err;
	assign stat_ev[ST_ZERO]  = zero_pulse;
	assign stat_ev[ST_SHUNT] = shunt_chg;
	assign stat_ev[ST_SERR]  = smp_valid && |smp_err;

	// A new event in the clearing read cycle survives the clear.
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			stat_q <= '0;
			irq_q  <= 1'b0;
		end
		else
		begin
			stat_q <= (rd_go && s_axi_araddr == A_STAT ? '0 : stat_q) | stat_ev;
			irq_q  <= |(((rd_go && s_axi_araddr == A_STAT ? '0 : stat_q) | stat_ev)
				& reg_q[A_MASK[6:2]][ST_W-1:0]);
		end
	end
	assign irq = irq_q;

	// ****************************************
	// Channels
	// ****************************************
	assign ctrl      = reg_q[A_CTRL[6:2]];
	assign meas      = ctrl[C_MEAS];
	assign measuring = meas;
	assign n_eff     = reg_q[A_DECIM[6:2]][15:0] == 16'h0000 ? 16'h0001 : reg_q[A_DECIM[6:2]][15:0];
	assign fire      = smp_valid && meas && dec_q == 16'h0000; // see [RULE3]

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			dec_q <= 16'h0000;
		else if (!meas)
			dec_q <= 16'h0000;
		else if (smp_valid)
			dec_q <= dec_q + 16'h0001 >= n_eff ? 16'h0000 : dec_q + 16'h0001; // see [RULE3]
	end

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		logic [15:0] adj;
		assign adj = smp_data[c*16 +: 16] - zofs_q[c];
		always_ff @(posedge ref_clk or posedge reset)
		begin
			if (reset)
			begin
				raw_q[c]  <= 16'h0000;
				zofs_q[c] <= 16'h0000;
				val_q[c]  <= 16'h0000;
			end
			else
			begin
				if (smp_valid && !smp_err[c])
					raw_q[c] <= smp_data[c*16 +: 16];
				if (zero_pulse && reg_q[A_AZEN[6:2]][c])
					zofs_q[c] <= raw_q[c]; // see [RULE14]
				if (smp_valid)
					val_q[c] <= !smp_err[c] ? adj : ctrl[C_STDERR] ? val_q[c] : NEG_FS; // see [RULE16]
			end
		end
		a_zero_adj: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE14]
			zero_pulse && reg_q[A_AZEN[6:2]][c] |=> zofs_q[c] == $past(raw_q[c]))
			else $error("Zero offset not taken from the current sample.");
		a_err_negfs: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE16]
			smp_valid && smp_err[c] && !ctrl[C_STDERR] |=> val_q[c] == NEG_FS)
			else $error("Transmission error did not give negative full scale.");
	end

	// ****************************************
	// Remote control
	// ****************************************
	ctp_rc_rx u_rc (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.rx_valid     (rx_valid),
		.rx_id        (rx_id),
		.rx_ext       (rx_ext),
		.rx_data      (rx_data),
		.cfg_ext      (ctrl[C_EXT]),
		.zero_id      (reg_q[A_ZID[6:2]][28:0]),
		.shunt_id     (reg_q[A_SID[6:2]][28:0]),
		.zero_act     (ctrl[C_ZACT]),
		.shunt_act    (ctrl[C_SACT]),
		.zero_pos     (reg_q[A_BITPOS[6:2]][BP_Z +: 6]),
		.shunt_pos    (reg_q[A_BITPOS[6:2]][BP_S +: 6]),
		.zero_pulse_q (zero_pulse),
		.shunt_chg_q  (shunt_chg),
		.shunt_q      (shunt_on)
	);
	assign test_resistor_on  = shunt_on;
	assign test_resistor_off = !shunt_on;

	// ****************************************
	// Frame building
	// ****************************************
	for (genvar m = 0; m < NMSG; m++)
	begin : g_act
		assign act[m] = reg_q[msg_ix(1'(m), MO_ID)][ID_ACT]; // see [RULE4]
	end

	always_comb
	begin
		sel = '0;
		for (int m = NMSG - 1; m >= 0; m--)
			if (pend_q[m])
				sel = 1'(m);
	end

	assign len_eff = reg_q[msg_ix(cur_q, MO_LEN)][3:0] > MAX_LEN ? MAX_LEN : reg_q[msg_ix(cur_q, MO_LEN)][3:0]; // see [RULE5]

	// Each message holds at most four slots, each naming one of the channels.
	for (genvar k = 0; k < NSLOT; k++)
	begin : g_slot
		logic [31:0] sw;
		assign sw = reg_q[msg_ix(cur_q, 3'(int'(MO_SLOT) + k))]; // see [RULE9]
		ctp_slot_fmt u_fmt (
			.value     (val_q[sw[SL_CH +: 3]]),
			.bit_ofs   (sw[SL_OFS +: 6]),
			.use_slot  (sw[SL_USE]),
			.is_signed (sw[SL_SGN]),
			.big_end   (sw[SL_BIG]),
			.field     (fld[k])
		);
	end

	for (genvar b = 0; b < 8; b++)
	begin : g_len
		assign len_mask[b*8 +: 8] = 4'(b) < len_eff ? 8'hFF : 8'h00; // see [RULE5] [RULE19]
	end
	assign payload = (fld[0] | fld[1] | fld[2] | fld[3]) & len_mask; // see [RULE19]

	// ****************************************
	// Transmit scheduling
	// ****************************************
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			pend_q <= '0;
		else if (!meas)
			pend_q <= '0; // see [RULE15]
		else
			pend_q <= ((st_q == S_IDLE && !halt_q ? pend_q & ~(NMSG'(1) << sel) : pend_q)
				| (fire ? act : '0)) & act; // see [RULE4]
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			st_q      <= S_IDLE;
			cur_q     <= '0;
			halt_q    <= 1'b0;
			tx_id_q   <= 29'h0000_0000;
			tx_ext_q  <= 1'b0;
			tx_dlc_q  <= 4'h0;
			tx_data_q <= 64'h0;
		end
		else
		begin
			if (!meas)
				halt_q <= 1'b0;
			case (st_q)
				S_IDLE:
					if (meas && !halt_q && |pend_q) // see [RULE15]
					begin
						cur_q <= sel;
						st_q  <= S_BUILD;
					end
				S_BUILD:
				begin
					tx_ext_q  <= ctrl[C_EXT];
					tx_id_q   <= reg_q[msg_ix(cur_q, MO_ID)][28:0] & (ctrl[C_EXT] ? 29'h1FFF_FFFF : STD_IDMASK); // see [RULE1]
					tx_dlc_q  <= len_eff;
					tx_data_q <= payload;
					st_q      <= S_SEND;
				end
				S_SEND:
					if (tx_ready)
						st_q <= S_WAIT;
				S_WAIT:
					if (tx_done || tx_ack_err)
					begin
						st_q <= S_IDLE;
						if (tx_ack_err && !ctrl[C_IGNACK] && meas)
							halt_q <= 1'b1; // see [RULE2]
					end
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

	// Data holds during back-pressure because it only changes in the build state.
	assign tx_valid = st_q == S_SEND;
	assign tx_id    = tx_id_q;
	assign tx_ext   = tx_ext_q;
	assign tx_dlc   = tx_dlc_q;
	assign tx_data  = tx_data_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_meas_gate: assert property (st_q == S_IDLE && !meas |=> st_q == S_IDLE) // see [RULE15]
		else $error("Frame started outside measuring mode.");
	a_std_id: assert property (tx_valid && !tx_ext |-> tx_id[28:11] == 18'h0) // see [RULE1]
		else $error("Standard frame carries identifier bits above bit 10.");
	a_dlc_max: assert property (tx_valid |-> tx_dlc <= MAX_LEN) // see [RULE5]
		else $error("Payload length above eight bytes.");
	a_pad_zero: assert property (tx_valid |-> (tx_data >> {tx_dlc, 3'h0}) == 64'h0) // see [RULE19]
		else $error("Payload bits beyond the length are not zero.");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_id))
		else $error("Frame changed while waiting for the controller.");
	a_ack_halt: assert property (st_q == S_WAIT && tx_ack_err && !ctrl[C_IGNACK] && meas |=> halt_q) // see [RULE2]
		else $error("Missing acknowledge did not stop transmission.");
	a_ack_keep: assert property (st_q == S_WAIT && tx_ack_err && ctrl[C_IGNACK] && !halt_q |=> !halt_q) // see [RULE2]
		else $error("Transmission stopped although acknowledge is ignored.");
	a_decim_run: assert property (fire && n_eff != 16'h0001 && meas |=> dec_q == 16'h0001) // see [RULE3]
		else $error("Decimation counter did not advance after a sent sample.");
	a_pend_act: assert property (|(pend_q & ~act) |-> $changed(act)) // see [RULE4]
		else $error("Inactive message left pending.");

	c_frame_sent: cover property (st_q == S_WAIT && tx_done);
	c_ack_error: cover property (st_q == S_WAIT && tx_ack_err);
	c_zero_adj: cover property (zero_pulse);
	c_shunt_on: cover property (shunt_chg && !shunt_on ##1 shunt_on);

endmodule : ctp_packer

// >>> verification/ctp_can_peer.sv
`timescale 1ns/100ps
module ctp_can_peer
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Transmit side
	input  wire logic        tx_valid,
	output logic             tx_ready,
	input  wire logic [28:0] tx_id,
	input  wire logic [3:0]  tx_dlc,
	input  wire logic [63:0] tx_data,
	output logic             tx_done,
	output logic             tx_ack_err,
	input  wire logic        nack,
	// Receive side
	output logic             rx_valid,
	output logic      [28:0] rx_id,
	output logic      [63:0] rx_data,
	// Capture
	output logic      [7:0]  n_fr,
	output logic      [96:0] last
);
	logic [2:0] dly_q;
	initial
	begin
		{rx_valid, rx_id, rx_data} = '0;
	end
	// One level bit per remote function at its position.
	task automatic send(input logic [28:0] id, input logic [63:0] d);
		@(posedge ref_clk);
		{rx_valid, rx_id, rx_data} <= {1'b1, id, d};
		@(posedge ref_clk);
		// A released bus must not look like a repeat of the frame.
		{rx_valid, rx_id, rx_data} <= {1'b0, ~id, ~d};
	endtask : send
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			{tx_ready, tx_done, tx_ack_err, dly_q, n_fr, last} <= '0;
		end
		else
		begin
			tx_ready <= tx_valid & ~tx_ready & (dly_q == 3'h0);
			tx_done <= (dly_q == 3'h1) & ~nack;
			// Without acknowledge the controller reports an error instead.
			tx_ack_err <= (dly_q == 3'h1) & nack;
			if (tx_valid & tx_ready)
			begin
				dly_q <= 3'h4;
				n_fr <= n_fr + 8'h1;
				last <= {tx_id, tx_dlc, tx_data};
			end
			else if (dly_q != 3'h0)
				dly_q <= dly_q - 3'h1;
		end
	end
endmodule : ctp_can_peer

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench import ctp_pkg::*;
();
	logic        ref_clk, reset, auto_measure, smp_valid, tx_ready, tx_done, tx_ack_err, rx_valid, rx_ext, nack;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, tx_valid, tx_ext;
	logic        test_resistor_on, test_resistor_off, measuring;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, n_fr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb, tx_dlc;
	logic [28:0] tx_id, rx_id;
	logic [63:0] tx_data, rx_data;
	logic [96:0] last;
	logic [NCH*16-1:0] smp_data;
	logic [NCH-1:0]    smp_err;
	int          n_errors, samples_checked;
	ctp_packer dut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .auto_measure, .smp_valid,
		.smp_data, .smp_err, .tx_valid, .tx_ready, .tx_id, .tx_ext, .tx_dlc, .tx_data, .tx_done, .tx_ack_err,
		.rx_valid, .rx_id, .rx_ext, .rx_data, .test_resistor_on, .test_resistor_off, .measuring);
	ctp_can_peer peer (.ref_clk, .reset, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .tx_done,
		.tx_ack_err, .nack, .rx_valid, .rx_id, .rx_data, .n_fr, .last);
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [7:0] ma(input int m, input int o);
		return A_MSG0 + 8'(4 * (MSG_STRIDE * m + o));
	endfunction : ma
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// Ready is sampled at the falling edge, where it already shows its value for the next rising edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		logic [1:0] br;
		@(posedge ref_clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		b = 1'b0;
		while (!b)
		begin
			@(negedge ref_clk);
			{aw, w, b, br} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge ref_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		chk(br, RESP_OK);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ar, r;
		logic [33:0] got;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		r = 1'b0;
		while (!r)
		begin
			@(negedge ref_clk);
			{ar, r, got} = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
			@(posedge ref_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		chk(got, {er, exp});
	endtask : rd
	task automatic smp(input logic [NCH-1:0] e);
		@(posedge ref_clk);
		{smp_valid, smp_data, smp_err} <= {1'b1, 80'h0, 48'h5555_ABCD_1234, e};
		@(posedge ref_clk);
		smp_valid <= 1'b0;
	endtask : smp
	task automatic fr(input logic [7:0] n);
		repeat (40) @(posedge ref_clk);
		chk(n_fr, n);
	endtask : fr
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		stop_test();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{auto_measure, smp_valid, smp_err, nack, rx_ext, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, smp_data, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		reset = 1'b1;
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		wr(ma(0, MO_ID), 32'h9FFF_F123);
		wr(ma(0, MO_LEN), 32'h4);
		wr(ma(0, 2), 32'h008);
		wr(ma(0, 3), 32'hD09);
		wr(ma(0, 4), 32'h28A);
		wr(ma(1, MO_ID), 32'h0AA);
		wr(ma(1, 2), 32'h008);
		wr(A_DECIM, 32'h2);
		wr(A_MASK, 32'h1);
		chk({measuring, test_resistor_off}, 2'h1);
		wr(A_CTRL, 32'h4);
		smp(8'h0);
		fr(8'h1);
		chk(last, {29'h123, 4'h4, 64'h0000_0000_CDAB_9234});
		chk(irq, 1'b1);
		rd(A_STAT, 32'h1, RESP_OK);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		smp(8'h0);
		fr(8'h1);
		smp(8'h1);
		fr(8'h2);
		chk(last[63:0], 64'h0000_0000_CDAB_0000);
		$display("test frames done");
		wr(A_CTRL, 32'h0);
		smp(8'h0);
		fr(8'h2);
		wr(A_DECIM, 32'h1);
		wr(A_CTRL, 32'h6);
		nack <= 1'b1;
		smp(8'h0);
		smp(8'h0);
		fr(8'h4);
		$display("test modes done");
		nack <= 1'b0;
		wr(A_SID, 32'h055);
		wr(A_ZID, 32'h066);
		wr(A_BITPOS, 32'h0300);
		wr(A_AZEN, 32'h1);
		wr(A_CTRL, 32'h34);
		peer.send(29'h055, 64'h8);
		repeat (3) @(posedge ref_clk);
		chk({test_resistor_on, test_resistor_off}, 2'h2);
		peer.send(29'h066, 64'h1);
		smp(8'h0);
		fr(8'h5);
		chk(last[63:0], 64'h0000_0000_CDAB_8000);
		peer.send(29'h055, 64'h0);
		repeat (3) @(posedge ref_clk);
		chk(test_resistor_on, 1'b0);
		wr(A_CTRL, 32'h5);
		smp(8'h0);
		fr(8'h6);
		chk({tx_ext, last[96:68]}, {1'b1, 29'h1FFF_F123});
		wr(A_CTRL, 32'h0);
		peer.send(29'h055, 64'h8);
		repeat (3) @(posedge ref_clk);
		chk(test_resistor_on, 1'b0);
		rd(8'hFC, 32'h0, RESP_ERR);
		$display("test remote done");
		auto_measure <= 1'b1;
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({measuring, test_resistor_on}, 2'h2);
		$display("test reset done");
		stop_test();
	end
endmodule : testbench
